//--- rtl/sdcl_pkg.sv
package sdcl_pkg;

	// -----------------------------------------------------------------
	// Code and frame geometry.
	// -----------------------------------------------------------------
	localparam int CODE_W      = 14;
	localparam int FRAME_MAX_W = 16;
	localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
	localparam logic [CODE_W-1:0] CODE_ZERO  = 14'h0000;

	// -----------------------------------------------------------------
	// Synchroniser depth for levels crossing into the system clock.
	// -----------------------------------------------------------------
	localparam int SYNC_STAGES = 2;

	// Snapshot of a load as it crosses from the link domain.
	typedef struct packed {
		logic              toggle;
		logic [CODE_W-1:0] code;
	} sdcl_load_type;

	// Load tracker states, Gray coded along the idle to take path.
	typedef enum logic [1:0] {
		SDCL_IDLE = 2'b00,
		SDCL_WAIT = 2'b01,
		SDCL_TAKE = 2'b11
	} sdcl_state_type;

endpackage

//--- rtl/sdcl_sync.sv
`timescale 1ns/10ps
module sdcl_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = sdcl_pkg::SYNC_STAGES
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage_r [STAGES];

	// -----------------------------------------------------------------
	// Plain flop chain; only the last stage leaves this module.
	// -----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < STAGES; k++) begin
				stage_r[k] <= '0;
			end
		end else begin
			stage_r[0] <= i_async;
			for (int k = 1; k < STAGES; k++) begin
				stage_r[k] <= stage_r[k-1];
			end
		end
	end

	assign o_sync = stage_r[STAGES-1];

endmodule // sdcl_sync

//--- rtl/sdcl_loader.sv
`timescale 1ns/10ps
module sdcl_loader #(
	parameter int CODE_W = sdcl_pkg::CODE_W
) (
	input  wire logic              i_clk,
	input  wire logic              i_reset,
	input  wire logic              i_link_clk,
	input  wire logic              i_select_n,
	input  wire logic              i_serial_in,
	output logic      [CODE_W-1:0] o_code,
	output logic                   o_code_valid,
	output logic      [CODE_W-1:0] o_link_code
);

	// -----------------------------------------------------------------
	// Link domain: shift register and holding register.
	// -----------------------------------------------------------------
	logic [CODE_W-1:0] shift_r;
	logic [CODE_W-1:0] shift_nxt;
	logic [CODE_W-1:0] hold_r;
	logic              load_tgl_r;

	// Only the newest CODE_W bits are kept, so leading bits of a longer
	// frame simply fall off the MSB end.
	assign shift_nxt = {shift_r[CODE_W-2:0], i_serial_in};

	// Shift on link clock edges only while select is low.
	always_ff @(posedge i_link_clk or posedge i_reset) begin
		if (i_reset) begin
			shift_r <= sdcl_pkg::CODE_ZERO;
		end else if (!i_select_n) begin
			shift_r <= shift_nxt;
		end
	end

	// The select rising edge is a clock of its own here; that mirrors the
	// pin behaviour without needing a free-running link clock after a frame.
	always_ff @(posedge i_select_n or posedge i_reset) begin
		if (i_reset) begin
			hold_r     <= sdcl_pkg::CODE_RESET;
			load_tgl_r <= 1'b0;
		end else begin
			hold_r     <= shift_r;
			load_tgl_r <= ~load_tgl_r;
		end
	end

	assign o_link_code = hold_r;

	// -----------------------------------------------------------------
	// Crossing into the system clock: toggle plus quasi-static word.
	// -----------------------------------------------------------------
	sdcl_pkg::sdcl_load_type load_async;
	sdcl_pkg::sdcl_load_type load_sync;
	sdcl_pkg::sdcl_load_type load_d_r;
	sdcl_pkg::sdcl_state_type state_r;
	sdcl_pkg::sdcl_state_type state_nxt;
	logic [CODE_W-1:0]       code_r;
	logic                    valid_r;
	logic                    toggle_seen;
	logic                    take_now;

	// Decode of the state that hands the crossed word to the system side.
	function automatic logic sdcl_is_take(input sdcl_pkg::sdcl_state_type st);
		return st == sdcl_pkg::SDCL_TAKE;
	endfunction

	assign load_async = '{toggle: load_tgl_r, code: hold_r};

	// Width follows the carrier itself, so a change of code width cannot misalign it.
	sdcl_sync #(
		.WIDTH ($bits(sdcl_pkg::sdcl_load_type)),
		.STAGES(sdcl_pkg::SYNC_STAGES)
	) u_sync (
		.i_clk  (i_clk),
		.i_reset(i_reset),
		.i_async(load_async),
		.o_sync (load_sync)
	);

	// A toggle change means a new word; wait one more cycle so the word,
	// stable long before the next select rise, has settled through the sync.
	// A second load landing before take is done is missed, so loads must be spaced.
	// That limitation was accepted to keep the crossing to a toggle and two flops.
	assign toggle_seen = load_sync.toggle ^ load_d_r.toggle;

	// The take state is decoded once and shared by the output registers.
	assign take_now = sdcl_is_take(state_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sdcl_pkg::SDCL_IDLE: begin
				if (toggle_seen) begin
					state_nxt = sdcl_pkg::SDCL_WAIT;
				end
			end
			sdcl_pkg::SDCL_WAIT: begin
				state_nxt = sdcl_pkg::SDCL_TAKE;
			end
			sdcl_pkg::SDCL_TAKE: begin
				state_nxt = sdcl_pkg::SDCL_IDLE;
			end
			default: begin
				state_nxt = sdcl_pkg::SDCL_IDLE;
			end
		endcase
	end

	// Register the crossed load and present the code on the system side.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			load_d_r <= '0;
			state_r  <= sdcl_pkg::SDCL_IDLE;
			code_r   <= sdcl_pkg::CODE_RESET;
			valid_r  <= 1'b0;
		end else begin
			load_d_r <= load_sync;
			state_r  <= state_nxt;
			valid_r  <= take_now;
			if (take_now) begin
				code_r <= load_sync.code;
			end
		end
	end

	assign o_code       = code_r;
	assign o_code_valid = valid_r;

	// -----------------------------------------------------------------
	// Checks.
	// -----------------------------------------------------------------
	property p_shift;
		@(posedge i_link_clk) disable iff (i_reset)
		!i_select_n |=> shift_r == {$past(shift_r[CODE_W-2:0]), $past(i_serial_in)};
	endproperty
	AST_SHIFT_ONE_BIT: assert property (p_shift)
		else $error("Shift register did not advance by one bit.");

	property p_idle;
		@(posedge i_link_clk) disable iff (i_reset)
		i_select_n && $past(i_select_n) |-> $stable(shift_r);
	endproperty
	AST_IDLE_NO_SHIFT: assert property (p_idle)
		else $error("Shift register changed while select was high.");

	// Sampled on the fast clock: two link edges of adjacent frames can straddle a load.
	property p_hold;
		@(posedge i_clk) disable iff (i_reset)
		!i_select_n && $past(!i_select_n) |-> $stable(hold_r);
	endproperty
	AST_HOLD_LATCHED: assert property (p_hold)
		else $error("Holding register changed during shifting.");

	property p_sys_hold;
		@(posedge i_clk) disable iff (i_reset)
		!valid_r |-> $stable(code_r);
	endproperty
	AST_CODE_STABLE: assert property (p_sys_hold)
		else $error("System code changed without a load.");

	sequence s_take;
		sdcl_is_take(state_r);
	endsequence
	property p_take;
		@(posedge i_clk) disable iff (i_reset)
		s_take |=> valid_r && code_r == $past(load_sync.code);
	endproperty
	AST_TAKE_CODE: assert property (p_take)
		else $error("Loaded code does not match crossed holding value.");

	// A toggle seen in idle walks through wait and take, so valid is seen three
	// samples later.
	property p_seen;
		@(posedge i_clk) disable iff (i_reset)
		toggle_seen && state_r == sdcl_pkg::SDCL_IDLE |-> ##3 valid_r;
	endproperty
	AST_LOAD_SEEN: assert property (p_seen)
		else $error("Load event did not raise code valid in time.");

	property p_pulse;
		@(posedge i_clk) disable iff (i_reset)
		valid_r |=> !valid_r;
	endproperty
	AST_VALID_PULSE: assert property (p_pulse)
		else $error("Code valid lasted more than one cycle.");

	property p_reset_zero;
		@(posedge i_clk)
		$fell(i_reset) |-> code_r == sdcl_pkg::CODE_RESET;
	endproperty
	AST_RESET_ZERO: assert property (p_reset_zero)
		else $error("Code not zero after reset.");

	// The holding register must show the shifted word right after select rises.
	property p_hold_from_shift;
		@(posedge i_clk) disable iff (i_reset)
		$rose(i_select_n) |-> hold_r == shift_r;
	endproperty
	AST_HOLD_FROM_SHIFT: assert property (p_hold_from_shift)
		else $error("Holding register did not take the shift register at select rise.");

	// With select idle high the holding register must not move.
	property p_hold_idle;
		@(posedge i_clk) disable iff (i_reset)
		i_select_n && $past(i_select_n) |-> $stable(hold_r);
	endproperty
	AST_HOLD_IDLE: assert property (p_hold_idle)
		else $error("Holding register changed while select stayed high.");

	// Both link-side registers must come out of reset at zero.
	property p_link_reset_zero;
		@(posedge i_clk)
		$fell(i_reset) |-> hold_r == sdcl_pkg::CODE_RESET && shift_r == sdcl_pkg::CODE_ZERO;
	endproperty
	AST_LINK_RESET_ZERO: assert property (p_link_reset_zero)
		else $error("Link-side registers not zero after reset.");

endmodule // sdcl_loader

//--- bench/sdcl_host.sv
`timescale 1ns/10ps
// Host end of the serial link; its clock only runs while a send is under way.
module sdcl_host (
	output logic o_link_clk,
	output logic o_select_n,
	output logic o_serial_in
);
	// Idle link: clock low, select high.
	initial begin
		o_link_clk = 1'b0;
		o_select_n = 1'b1;
		o_serial_in = 1'b0;
	end
	// Sends the low n bits of w, top bit first; sel low gives clocks with select high.
	task automatic send(input logic [15:0] w, input int n, input logic sel);
		o_select_n = ~sel;
		#15;
		for (int k = n - 1; k >= 0; k--) begin
			o_serial_in = w[k];
			#15 o_link_clk = 1'b1;
			#15 o_link_clk = 1'b0;
		end
		o_serial_in = ~o_serial_in; // The released line shows no stale bit.
		#15 o_select_n = 1'b1;
		#1;
	endtask
endmodule // sdcl_host

//--- bench/serial_dac_code_loader_bench.sv
`timescale 1ns/10ps
module serial_dac_code_loader_bench;
	logic                        i_clk;
	logic                        i_reset;
	logic                        link_clk;
	logic                        select_n;
	logic                        serial_in;
	logic                        o_code_valid;
	logic [sdcl_pkg::CODE_W-1:0] o_code;
	logic [sdcl_pkg::CODE_W-1:0] o_link_code;
	int                          bad_count = 0;
	int                          n_tests = 0;
	int                          cycles = 0;

	sdcl_loader sdcl_loader_i (.i_clk(i_clk), .i_reset(i_reset), .i_link_clk(link_clk),
		.i_select_n(select_n), .i_serial_in(serial_in), .o_code(o_code),
		.o_code_valid(o_code_valid), .o_link_code(o_link_code));
	sdcl_host sdcl_host_i (.o_link_clk(link_clk), .o_select_n(select_n),
		.o_serial_in(serial_in));

	// System clock, 5 ns period.
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// A hung run is cut short well past the few hundred cycles the tests need.
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [13:0] got, input logic [13:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One loaded frame; the system view must follow within a bounded wait.
	task automatic load(input logic [15:0] w, input int n, input logic [13:0] exp);
		logic seen;
		seen = 1'b0;
		sdcl_host_i.send(w, n, 1'b1);
		chk(o_link_code, exp);
		for (int t = 0; t < 12 && !seen; t++) begin
			@(negedge i_clk);
			seen = (o_code_valid === 1'b1);
		end
		chk({13'h0000, seen}, 14'h0001);
		chk(o_code, exp);
		@(negedge i_clk);
		chk({13'h0000, o_code_valid}, 14'h0000);
		repeat (4) @(negedge i_clk);
	endtask

	task automatic t_reset();
		chk(o_code, 14'h0000);
		chk(o_link_code, 14'h0000);
		$display("t_reset done");
	endtask

	task automatic t_full();
		load(16'h2A5B, 14, 14'h2A5B);
		load(16'hD2C7, 16, 14'h12C7);
		$display("t_full done");
	endtask

	// Clocks with select high must leave both registers alone.
	task automatic t_idle();
		sdcl_host_i.send(16'hFFFF, 5, 1'b0);
		repeat (10) @(negedge i_clk);
		chk(o_link_code, 14'h12C7);
		chk(o_code, 14'h12C7);
		$display("t_idle done");
	endtask

	// A short frame pushes four new bits in under the older ones.
	task automatic t_short();
		load(16'h0005, 4, 14'h2C75);
		$display("t_short done");
	endtask

	// Reset for two cycles, then the scenarios in turn.
	initial begin
		i_reset = 1'b1;
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		@(negedge i_clk);
		t_reset();
		t_full();
		t_idle();
		t_short();
		report_and_stop();
	end
endmodule // serial_dac_code_loader_bench
